// file: dv/test_ufh_frame_hub_regs.sv
// Purpose: self-checking bench for the frame and root hub register slice
// Assumes: inputs change on the falling clock edge
// Notes:   threshold set to its 11-bit top so the grant boundary is reachable
`timescale 1ns/1ps
module test_ufh_frame_hub_regs;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ctrlReset = 1'b0;
  logic        ctrlOperational = 1'b0;
  logic        bitTick = 1'b0;
  logic        cmdValid = 1'b0;
  logic [7:0]  cmdCode = 8'h00;
  logic [31:0] cmdWrData = 32'h0;
  logic        lsStartReq = 1'b0;
  wire         rdValid;
  wire  [31:0] rdData;
  wire  [15:0] frameCount;
  wire  [13:0] frameBitsLeft;
  wire         lsStartGrant;
  wire         descBWrite;
  wire         hubStatusWrite;
  wire  [1:0]  portStatusWrite;
  wire         frameStartSet;
  wire  [31:0] hubWrData;
  wire  [7:0]  portPowerGoodDelay;
  wire         noOvercurrentProtect;
  wire         overcurrentReportMode;
  wire         noPowerSwitch;
  wire         powerSwitchMode;
  int          badCount = 0;
  int          checkCount = 0;
  // rows: operational, code, write word, expected read or strobes
  logic [72:0] rows [0:17] = '{
    {1'b0, 8'h0F, 32'h0, 32'h0},
    {1'b0, 8'h11, 32'h0, 32'h628},
    {1'b0, 8'h12, 32'h0, 32'h01000902},
    {1'b0, 8'h92, 32'hFFFFFFFF, 32'h0},
    {1'b0, 8'h12, 32'h0, 32'hFF001B02},
    {1'b0, 8'h92, 32'h0, 32'h0},
    {1'b0, 8'h12, 32'h0, 32'h2},
    {1'b0, 8'h93, 32'h0, 32'h8},
    {1'b0, 8'h94, 32'h0, 32'h0},
    {1'b0, 8'h95, 32'h0, 32'h0},
    {1'b0, 8'h20, 32'h0, 32'h0},        // unmapped read
    {1'b1, 8'h94, 32'h0, 32'h4},
    {1'b1, 8'h0F, 32'h0, 32'h1},
    {1'b1, 8'h0E, 32'h0, 32'h2EDF},
    {1'b1, 8'h95, 32'h0, 32'h1},
    {1'b1, 8'h96, 32'h0, 32'h2},
    {1'b1, 8'h91, 32'hFFFFF7FF, 32'h0},
    {1'b1, 8'h11, 32'h0, 32'h7FF}};

  ufh_frame_hub_regs u_ufh_frame_hub_regs (
    .clock(clock), .rst(rst), .ctrlReset(ctrlReset), .ctrlOperational(ctrlOperational),
    .bitTick(bitTick), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
    .rdValid(rdValid), .rdData(rdData), .frameStartSet(frameStartSet),
    .frameCount(frameCount),
    .frameBitsLeft(frameBitsLeft), .lsStartReq(lsStartReq), .lsStartGrant(lsStartGrant),
    .descBWrite(descBWrite), .hubStatusWrite(hubStatusWrite),
    .portStatusWrite(portStatusWrite), .hubWrData(hubWrData),
    .portPowerGoodDelay(portPowerGoodDelay), .noOvercurrentProtect(noOvercurrentProtect),
    .overcurrentReportMode(overcurrentReportMode), .noPowerSwitch(noPowerSwitch),
    .powerSwitchMode(powerSwitchMode));

  ////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clock = ~clock;

  ////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // strobe held over exactly one rising edge
  task automatic cmd(input logic [7:0] code, input logic [31:0] data);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdWrData = data;
    @(negedge clock);
    cmdValid = 1'b0;
  endtask

  // bounded so a stuck counter cannot hang the run
  task automatic tickUntil(input logic [13:0] target);
    int n;
    n = 0;
    bitTick = 1'b1;
    while (frameBitsLeft !== target && n < 13000) begin
      @(negedge clock);
      n++;
    end
    bitTick = 1'b0;
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // watchdog, well beyond two frames of ticks
  initial begin
    #160000;
    badCount++;
    wrapUp();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [72:0] r;
    logic [15:0] fc;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    chk("frame count", 32'h0, {16'h0, frameCount});
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      ctrlOperational = r[72];
      cmd(r[71:64], r[63:32]);
      chk("command result", r[31:0], r[71] ? {28'h0, descBWrite, hubStatusWrite,
        portStatusWrite} : rdData);
      chk("read valid", {31'h0, !r[71]}, {31'h0, rdValid});
      if (r[71]) chk("write word", r[63:32], hubWrData);
      if (r[71:64] == 8'h12) begin
        chk("descriptor a fields", {20'h0, r[31:24], r[12], r[11], r[9], r[8]},
          {20'h0, portPowerGoodDelay, noOvercurrentProtect, overcurrentReportMode,
          noPowerSwitch, powerSwitchMode});
      end
      @(negedge clock);
    end
    $display("table test done");
    lsStartReq = 1'b1;
    tickUntil(14'h7FF);
    chk("grant at threshold", 32'h1, {31'h0, lsStartGrant});
    @(negedge clock);
    tickUntil(14'h7FE);
    chk("grant below threshold", 32'h0, {31'h0, lsStartGrant});
    lsStartReq = 1'b0;
    $display("grant test done");
    fc = frameCount;
    tickUntil(14'h2EDE);
    chk("bits left reload", 32'h2EDE, {18'h0, frameBitsLeft});
    chk("frame advance", {16'h0, fc + 16'h1}, {16'h0, frameCount});
    chk("frame start", 32'h1, {31'h0, frameStartSet});
    $display("frame test done");
    ctrlReset = 1'b1;
    ctrlOperational = 1'b0;
    @(negedge clock);
    ctrlReset = 1'b0;
    chk("count after reset", 32'h0, {16'h0, frameCount});
    cmd(8'h11, 32'h0);
    chk("threshold after reset", 32'h628, rdData);
    $display("controller reset test done");
    wrapUp();
  end
endmodule // test_ufh_frame_hub_regs

// file: dv/ufh_frame_hub_regs_properties.sv
// Purpose: concurrent checks on the frame and root hub register slice
// Assumes: one clock, rst asynchronous and active high
// Notes:   read data and strobes land one cycle after the command
`timescale 1ns/1ps
module ufh_regs_checker (
  input logic        clock,
  input logic        rst,
  input logic        ctrlReset,
  input logic        ctrlOperational,
  input logic        cmdValid,
  input logic [7:0]  cmdCode,
  input logic        rdValid,
  input logic [31:0] rdData,
  input logic        frameStartSet,
  input logic [15:0] frameCount,
  input logic [13:0] frameBitsLeft,
  input logic        lsStartReq,
  input logic        lsStartGrant,
  input logic        descBWrite,
  input logic        hubStatusWrite
);
  ////////////////////////////////////////////////////////////
  // single domain, so clock and disable are shared
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // command port answers
  rd_answer_timing_a: assert property (cmdValid && !cmdCode[7] |=> rdValid)
    else $error("read command got no answer");
  frame_read_value_a: assert property (
    cmdValid && cmdCode == 8'h0F |=> rdData == {16'h0, $past(frameCount)})
    else $error("frame number read wrong");
  thresh_read_upper_a: assert property (
    cmdValid && cmdCode == 8'h11 |=> rdData[31:11] == 21'h0)
    else $error("threshold reserved bits not zero");
  desc_a_fixed_a: assert property (
    cmdValid && cmdCode == 8'h12 |=> rdData[23:13] == 11'h0 && !rdData[10]
      && rdData[7:2] == 6'h0 && rdData[1:0] <= 2'h2)
    else $error("descriptor fixed bits wrong");
  hub_write_gate_a: assert property (
    cmdValid && cmdCode == 8'h94 |=> hubStatusWrite == $past(ctrlOperational))
    else $error("hub status write gating wrong");
  desc_b_any_a: assert property (cmdValid && cmdCode == 8'h93 |=> descBWrite)
    else $error("descriptor b write dropped");

  ////////////////////////////////////////////////////////////
  // frame timing; a controller reset may clear the count
  frame_step_one_a: assert property (
    frameCount != $past(frameCount) && !$past(ctrlReset)
      |-> frameCount == $past(frameCount) + 16'h1)
    else $error("frame count moved by other than one");
  frame_start_flag_a: assert property (
    frameCount != $past(frameCount) && !$past(ctrlReset) |-> ##[0:1] frameStartSet)
    else $error("frame start flag missing");
  op_entry_step_a: assert property (
    $rose(ctrlOperational) && !ctrlReset |=> frameCount == $past(frameCount) + 16'h1)
    else $error("operational entry did not step the frame count");
  bits_left_range_a: assert property (frameBitsLeft <= 14'h2EDF)
    else $error("bits left above frame period");
  grant_needs_req_a: assert property (!lsStartReq |-> !lsStartGrant)
    else $error("grant without request");
endmodule // ufh_regs_checker

bind ufh_frame_hub_regs ufh_regs_checker u_ufh_regs_checker (
  .clock, .rst, .ctrlReset, .ctrlOperational, .cmdValid, .cmdCode, .rdValid, .rdData,
  .frameStartSet, .frameCount, .frameBitsLeft, .lsStartReq, .lsStartGrant,
  .descBWrite, .hubStatusWrite
);

// file: rtl/ufh_frame_hub_regs.v
// Purpose: frame number, low-speed threshold and root hub descriptor A
// Assumes: command port and controller state come from same-clock logic
// Notes:   read data is registered and valid the cycle after the command
`timescale 1ns/1ps
`include "ufh_defs.vh"

module ufh_frame_hub_regs (
  clock,
  rst,
  ctrlReset,
  ctrlOperational,
  bitTick,
  cmdValid,
  cmdCode,
  cmdWrData,
  rdValid,
  rdData,
  frameStartSet,
  frameCount,
  frameBitsLeft,
  lsStartReq,
  lsStartGrant,
  descBWrite,
  hubStatusWrite,
  portStatusWrite,
  hubWrData,
  portPowerGoodDelay,
  noOvercurrentProtect,
  overcurrentReportMode,
  noPowerSwitch,
  powerSwitchMode
);
  input         clock;
  input         rst;
  input         ctrlReset;
  input         ctrlOperational;
  input         bitTick;
  input         cmdValid;
  input  [7:0]  cmdCode;
  input  [31:0] cmdWrData;
  output        rdValid;
  output [31:0] rdData;
  output        frameStartSet;
  output [15:0] frameCount;
  output [13:0] frameBitsLeft;
  input         lsStartReq;
  output        lsStartGrant;
  output        descBWrite;
  output        hubStatusWrite;
  output [1:0]  portStatusWrite;
  output [31:0] hubWrData;
  output [7:0]  portPowerGoodDelay;
  output        noOvercurrentProtect;
  output        overcurrentReportMode;
  output        noPowerSwitch;
  output        powerSwitchMode;

  ////////////////////////////////////////////////////////////////////
  // state
  reg    [15:0] frameCount_q;      // running frame number
  reg    [15:0] frameCount_d;      // next frame number
  reg           frameStart_q;      // one-cycle frame-start pulse
  reg           opSeen_q;          // operational level, last cycle
  reg    [10:0] lsThreshold_q;     // low-speed commit threshold
  reg    [7:0]  pwrGoodDelay_q;    // port power-good delay, 2 ms units
  reg           noOcProtect_q;     // no overcurrent protection
  reg           ocReportMode_q;    // per-port overcurrent reporting
  reg           noPwrSwitch_q;     // ports always powered
  reg           pwrSwitchMode_q;   // per-port power switching
  reg           rdValid_q;         // read answer strobe
  reg    [31:0] rdData_q;          // read answer word
  reg    [31:0] rdData_d;          // read mux output
  reg           rdHit_d;           // command is a known read
  reg           descBWr_q;         // descriptor B write strobe
  reg           hubStatWr_q;       // hub status write strobe
  reg    [1:0]  portStatWr_q;      // port status write strobes
  reg    [31:0] hubWrData_q;       // word for the strobes above

  wire          opEnter;           // rising edge of operational
  wire          timerReload;       // bits-left reload pulse
  wire   [13:0] bitsLeft;          // bits left in frame
  wire          isWrite;           // command is a write
  wire          countStep;         // frame count advances now
  wire   [31:0] descAWord;         // assembled descriptor A

  ////////////////////////////////////////////////////////////////////
  // helpers
  // matches a command against a code, only when a command is offered
  // one function so every write-code decoder below applies the very same test; the read mux uses a case
  function hit;
    input       valid;
    input [7:0] code;
    input [7:0] want;
    begin
      hit = valid && (code == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // frame timer
  // the down-counter lives in its own module; only its reload pulse
  // and count come back, so the frame number logic stays small
  ufh_frame_timer u_ufh_frame_timer (
    .clock       (clock),
    .rst         (rst),
    .ctrlReset   (ctrlReset),
    .operational (ctrlOperational),
    .opEnter     (opEnter),
    .bitTick     (bitTick),
    .bitsLeft    (bitsLeft),
    .reloadPulse (timerReload)
  );

  // entry into the operational state, seen once per entry
  // a controller reset clears the tracker, so a later entry steps again
  assign opEnter   = ctrlOperational && !opSeen_q;
  assign isWrite   = cmdCode[7];
  // entry also counts as a reload, so the number steps with no software
  assign countStep = timerReload || opEnter;

  ////////////////////////////////////////////////////////////////////
  // operational edge tracker
  // starts low, so a controller already operational at release steps once
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      opSeen_q <= 1'b0;
    end else if (ctrlReset) begin
      opSeen_q <= 1'b0;
    end else begin
      opSeen_q <= ctrlOperational;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frame number next value
  // entry into operational steps it too, so software sees frame one
  always @* begin
    frameCount_d = frameCount_q;
    if (countStep) begin
      // plain modulo add: all-ones rolls to zero, no flag
      frameCount_d = frameCount_q + 16'h0001;
    end
  end

  // frame number and frame-start pulse
  // the pulse is registered beside the count, so both change on one edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      frameCount_q <= `UFH_FCNT_RESET;
      frameStart_q <= 1'b0;
    end else if (ctrlReset) begin
      // reset wins over a step landing in the same cycle
      frameCount_q <= `UFH_FCNT_RESET;
      frameStart_q <= 1'b0;
    end else begin
      frameCount_q <= frameCount_d;
      // the status register elsewhere holds it sticky
      frameStart_q <= countStep;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // low-speed threshold
  // only the write code and a controller reset change it; no other hardware path touches it
  // software is trusted to set it once at start-up; a later write is
  // still taken, since refusing it would need a lock nobody can read
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lsThreshold_q <= `UFH_THR_RESET;
    end else if (ctrlReset) begin
      lsThreshold_q <= `UFH_THR_RESET;
    end else if (hit(cmdValid, cmdCode, `UFH_CMD_LS_THRESH_WR)) begin
      // whole word taken, bits above the field dropped
      lsThreshold_q <= cmdWrData[`UFH_THR_MSB:0];
    end
  end

  // commit decision: worst-case eight-byte packet must fit in frame
  // combinational so a request is answered in its own cycle
  assign lsStartGrant = lsStartReq &&
                        (bitsLeft >= {3'b000, lsThreshold_q});

  ////////////////////////////////////////////////////////////////////
  // root hub descriptor A writable fields
  // accepted in every controller state, operational or not
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pwrGoodDelay_q  <= `UFH_DA_PGD_RESET;
      noOcProtect_q   <= `UFH_DA_NOOC_RESET;
      // overcurrent mode starts out matching the switching mode
      ocReportMode_q  <= `UFH_DA_OCRM_RESET;
      noPwrSwitch_q   <= `UFH_DA_NOSW_RESET;
      pwrSwitchMode_q <= `UFH_DA_SWM_RESET;
    end else if (hit(cmdValid, cmdCode, `UFH_CMD_DESC_A_WR)) begin
      // one whole word; compound-device, port count and reserved dropped
      // no controller-reset branch: these describe the board, not state
      pwrGoodDelay_q  <= cmdWrData[`UFH_DA_PGD_MSB:`UFH_DA_PGD_LSB];
      noOcProtect_q   <= cmdWrData[`UFH_DA_NOOC_BIT];
      ocReportMode_q  <= cmdWrData[`UFH_DA_OCRM_BIT];
      noPwrSwitch_q   <= cmdWrData[`UFH_DA_NOSW_BIT];
      pwrSwitchMode_q <= cmdWrData[`UFH_DA_SWM_BIT];
    end
  end

  // assembled descriptor A; fixed zeros for reserved and compound bits
  assign descAWord = {pwrGoodDelay_q,          // 31..24
                      11'h000,                 // 23..13 reserved
                      noOcProtect_q,           // 12
                      ocReportMode_q,          // 11
                      1'b0,                    // 10 compound
                      noPwrSwitch_q,           // 9
                      pwrSwitchMode_q,         // 8
                      6'h00,                   // 7..2 reserved
                      `UFH_DA_PCNT_VALUE};     // port count

  ////////////////////////////////////////////////////////////////////
  // forwarded hub write strobes
  // descriptor B always; hub and port status only when operational
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      descBWr_q    <= 1'b0;
      hubStatWr_q  <= 1'b0;
      portStatWr_q <= 2'b00;
      hubWrData_q  <= 32'h00000000;
    end else begin
      descBWr_q    <= hit(cmdValid, cmdCode, `UFH_CMD_DESC_B_WR);
      // a status write outside operational is dropped with no error;
      // software gets no sign of it, so it must order its start-up
      hubStatWr_q  <= ctrlOperational &&
                      hit(cmdValid, cmdCode, `UFH_CMD_HUB_STAT_WR);
      portStatWr_q <= {ctrlOperational &&
                       hit(cmdValid, cmdCode, `UFH_CMD_PORT2_STAT_WR),
                       ctrlOperational &&
                       hit(cmdValid, cmdCode, `UFH_CMD_PORT1_STAT_WR)};
      if (cmdValid && isWrite) begin
        // full word kept so downstream never sees a partial update
        hubWrData_q <= cmdWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux
  always @* begin
    rdData_d = 32'h00000000;
    rdHit_d  = 1'b1;
    case (cmdCode)
      `UFH_CMD_FRAME_NUM_RD: begin
        // upper half reserved, reads zero
        rdData_d = {16'h0000, frameCount_q};
      end
      `UFH_CMD_BITS_LEFT_RD: begin
        // live down-count; the bits above it read zero
        rdData_d = {18'h0, bitsLeft};
      end
      `UFH_CMD_LS_THRESH_RD: begin
        rdData_d = {21'h0, lsThreshold_q};
      end
      `UFH_CMD_DESC_A_RD: begin
        rdData_d = descAWord;
      end
      default: begin
        // unknown codes answer zero
        rdHit_d = 1'b0;
      end
    endcase
  end

  // read answer register; writes never raise rdValid
  // data loads on reads only, so it stands for software to pick up late
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdValid_q <= 1'b0;
      rdData_q  <= 32'h00000000;
    end else begin
      rdValid_q <= cmdValid && !isWrite;
      if (cmdValid && !isWrite) begin
        rdData_q <= rdHit_d ? rdData_d : 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  // every data output is a flop; only the grant is combinational
  assign rdValid               = rdValid_q;
  assign rdData                = rdData_q;
  assign frameStartSet         = frameStart_q;
  assign frameCount            = frameCount_q;
  assign frameBitsLeft         = bitsLeft;
  assign descBWrite            = descBWr_q;
  assign hubStatusWrite        = hubStatWr_q;
  assign portStatusWrite       = portStatWr_q;
  assign hubWrData             = hubWrData_q;
  assign portPowerGoodDelay    = pwrGoodDelay_q;
  assign noOvercurrentProtect  = noOcProtect_q;
  assign overcurrentReportMode = ocReportMode_q;
  assign noPowerSwitch         = noPwrSwitch_q;
  assign powerSwitchMode       = pwrSwitchMode_q;
endmodule // ufh_frame_hub_regs

// file: rtl/ufh_frame_timer.v
// Purpose: frame bits-left down-counter with reload pulse
// Assumes: bitTick is a one-cycle pulse per bit time, same clock
// Notes:   runs only while the controller is operational
`timescale 1ns/1ps
`include "ufh_defs.vh"

module ufh_frame_timer (
  clock,
  rst,
  ctrlReset,
  operational,
  opEnter,
  bitTick,
  bitsLeft,
  reloadPulse
);
  input         clock;
  input         rst;
  input         ctrlReset;
  input         operational;
  input         opEnter;
  input         bitTick;
  output [13:0] bitsLeft;
  output        reloadPulse;

  reg    [13:0] bitsLeft_q;    // bits remaining in frame
  reg           reloadPulse_q; // one cycle per reload

  assign bitsLeft    = bitsLeft_q;
  assign reloadPulse = reloadPulse_q;

  ////////////////////////////////////////////////////////////////////
  // down-count per bit time, reload one bit time after zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bitsLeft_q    <= 14'h0000;
      reloadPulse_q <= 1'b0;
    end else if (ctrlReset) begin
      bitsLeft_q    <= 14'h0000;
      reloadPulse_q <= 1'b0;
    end else begin
      reloadPulse_q <= 1'b0;
      if (opEnter) begin
        // fresh period on entry; the count step is handled upstream
        bitsLeft_q <= `UFH_FRAME_PERIOD;
      end else if (operational && bitTick) begin
        if (bitsLeft_q == 14'h0000) begin
          bitsLeft_q    <= `UFH_FRAME_PERIOD;
          reloadPulse_q <= 1'b1;
        end else begin
          bitsLeft_q <= bitsLeft_q - 14'h0001;
        end
      end
    end
  end
endmodule // ufh_frame_timer

// file: shared/ufh_defs.vh
// Purpose: constants for the host frame and root hub register slice
// Assumes: command codes are eight bits, bit 7 marks a write
// Notes:   one guard; definitions only
//
// Notes on behaviour
// - frame count steps on each bits-left reload
// - frame count wraps all-ones to zero silently
// - entering operational state steps the count automatically
// - every count advance raises frame-start flag
// - frame number read-only, upper half zero
// - low-speed start only if bits-left >= threshold
// - threshold gates eight-byte low-speed packet commit
// - threshold resets to 1576, bits 31..11 reserved
// - threshold read code, separate write code
// - threshold altered only by its write code or a controller reset
// - root hub registers move as whole words
// - descriptor registers writable in every state
// - hub and port status writable when operational
// - descriptor A read code, separate write code
// - descriptor A writable fields with chosen resets
// - port count read-only; reserved bits read zero
// - bits-left counts down, reloads period after zero
// - compound-device bit reads zero, writes ignored
// - port count reports at most two ports
`ifndef UFH_DEFS_VH
`define UFH_DEFS_VH

// command codes (read / write)
`define UFH_CMD_BITS_LEFT_RD   8'h0E
`define UFH_CMD_FRAME_NUM_RD   8'h0F
`define UFH_CMD_LS_THRESH_RD   8'h11
`define UFH_CMD_LS_THRESH_WR   8'h91
`define UFH_CMD_DESC_A_RD      8'h12
`define UFH_CMD_DESC_A_WR      8'h92
`define UFH_CMD_DESC_B_WR      8'h93
`define UFH_CMD_HUB_STAT_WR    8'h94
`define UFH_CMD_PORT1_STAT_WR  8'h95
`define UFH_CMD_PORT2_STAT_WR  8'h96

// field positions
`define UFH_FCNT_MSB           15
`define UFH_THR_MSB            10
`define UFH_BL_MSB             13
`define UFH_DA_PGD_LSB         24
`define UFH_DA_PGD_MSB         31
`define UFH_DA_NOOC_BIT        12
`define UFH_DA_OCRM_BIT        11
`define UFH_DA_CMPD_BIT        10
`define UFH_DA_NOSW_BIT        9
`define UFH_DA_SWM_BIT         8
`define UFH_DA_PCNT_MSB        1

// reset values
`define UFH_FCNT_RESET         16'h0000
`define UFH_THR_RESET          11'h628
`define UFH_FRAME_PERIOD       14'h2EDF
`define UFH_DA_PGD_RESET       8'h01
`define UFH_DA_NOOC_RESET      1'b0
`define UFH_DA_NOSW_RESET      1'b0
`define UFH_DA_SWM_RESET       1'b1
`define UFH_DA_OCRM_RESET      `UFH_DA_SWM_RESET
`define UFH_DA_PCNT_VALUE      2'h2

`endif
